// ==== core/hall_dsp_pkg.sv ====
// Purpose: Shared constants and types of the output-conditioning path
// Assumes: Output units are supply/2048, sensitivity units are 1/2048
// Notes: Command port carries decoded supply-modulation commands

package hall_dsp_pkg;

    // ==========================================================
    // Widths
    localparam int RAW_W = 14;
    localparam int SENS_W = 14;
    localparam int OFS_W = 11;
    localparam int CLAMP_W = 12;
    localparam int MODE_W = 6;
    localparam int SEL_W = 3;
    localparam int DATA_W = 16;
    localparam int PROD_W = 28;
    localparam int SUM_W = 18;

    // ==========================================================
    // Scaling and limits
    localparam int SCALE_SHIFT = 11;
    localparam logic [CLAMP_W-1:0] FULL_SCALE = 12'h800;
    localparam logic [CLAMP_W-1:0] HALF_SCALE = 12'h400;
    localparam int RANGE_LSB = 0;
    localparam int FILTER_LSB = 3;
    localparam int FIELD3_W = 3;

    // ==========================================================
    // Register selects
    localparam logic [SEL_W-1:0] SEL_MODE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_SENS = 3'h1;
    localparam logic [SEL_W-1:0] SEL_OFFSET = 3'h2;
    localparam logic [SEL_W-1:0] SEL_CLAMP_LO = 3'h3;
    localparam logic [SEL_W-1:0] SEL_CLAMP_HI = 3'h4;
    localparam logic [SEL_W-1:0] SEL_RAW = 3'h5;
    localparam logic [SEL_W-1:0] SEL_LOCK = 3'h6;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        OP_READ = 2'b00,
        OP_WRITE = 2'b01,
        OP_STORE = 2'b10,
        OP_LOCK = 2'b11
    } op_type;

    typedef enum logic {
        PH_LOAD = 1'b0,
        PH_RUN = 1'b1
    } phase_type;

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [SENS_W-1:0] sens;
        logic [OFS_W-1:0] offset;
        logic [CLAMP_W-1:0] clamp_lo;
        logic [CLAMP_W-1:0] clamp_hi;
    } settings_type;

    typedef struct packed {
        logic lock;
        settings_type set;
    } nv_type;

    typedef struct packed {
        logic valid;
        op_type op;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] data;
    } cmd_type;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } rsp_type;

    typedef struct packed {
        phase_type phase;
        logic lock;
        settings_type set;
        logic [RAW_W-1:0] raw;
        logic [PROD_W-1:0] prod;
        logic [SUM_W-1:0] sum;
        logic [SUM_W-1:0] ceil;
        rsp_type rsp;
        logic store;
    } cond_state_type;

    // ==========================================================
    // Reset values
    localparam settings_type SETTINGS_RST = '0;
    localparam logic LOCK_RST = 1'b1;

endpackage : hall_dsp_pkg

// ==== core/clamp_stage.sv ====
// Purpose: Saturating clamp of the offset-corrected value
// Assumes: If limits cross, lower limit wins only below it; values at or above it give the upper limit
// Notes: Output registered

`timescale 1ns/1ps

module clamp_stage
    import hall_dsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [hall_dsp_pkg::SUM_W-1:0] sum,
    input wire logic [hall_dsp_pkg::SUM_W-1:0] ceil,
    input wire logic [hall_dsp_pkg::CLAMP_W-1:0] clamp_lo,
    input wire logic [hall_dsp_pkg::CLAMP_W-1:0] clamp_hi,
    output logic [hall_dsp_pkg::CLAMP_W-1:0] dac_code
);
    import hall_dsp_pkg::*;

    typedef struct packed {
        logic [CLAMP_W-1:0] code;
    } clamp_state_type;

    clamp_state_type st_ff;
    clamp_state_type nxt_st;
    logic signed [SUM_W-1:0] lo_s;
    logic signed [SUM_W-1:0] hi_s;

    // ==========================================================
    // Saturation
    always_comb
    begin
        lo_s = $signed(SUM_W'(clamp_lo));
        hi_s = $signed(SUM_W'(clamp_hi));
        if ($signed(ceil) < hi_s)
        begin
            hi_s = $signed(ceil);
        end
        nxt_st = st_ff;
        if ($signed(sum) < lo_s)
        begin
            nxt_st.code = clamp_lo;
        end
        else if ($signed(sum) > hi_s)
        begin
            nxt_st.code = hi_s[CLAMP_W-1:0];
        end
        else
        begin
            nxt_st.code = sum[CLAMP_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign dac_code = st_ff.code;

    // ==========================================================
    // Checks
    property p_clamp_floor;
        @(posedge clock) disable iff (!rst_n)
        ($signed(sum) < $signed(SUM_W'(clamp_lo)))
        |=> (dac_code == $past(clamp_lo));
    endproperty
    a_clamp_floor: assert property (p_clamp_floor)
        else $error("output not held at lower limit");

    property p_clamp_pass;
        @(posedge clock) disable iff (!rst_n)
        ($signed(sum) >= $signed(SUM_W'(clamp_lo))
         && $signed(sum) <= $signed(SUM_W'(clamp_hi))
         && $signed(sum) <= $signed(ceil))
        |=> (dac_code == $past(sum[CLAMP_W-1:0]));
    endproperty
    a_clamp_pass: assert property (p_clamp_pass)
        else $error("in-window value altered");

    property p_clamp_top;
        @(posedge clock) disable iff (!rst_n)
        ($signed(sum) > $signed(SUM_W'(clamp_hi))
         && clamp_hi >= clamp_lo && $signed(ceil) >= $signed(SUM_W'(clamp_hi)))
        |=> (dac_code == $past(clamp_hi));
    endproperty
    a_clamp_top: assert property (p_clamp_top)
        else $error("output not held at upper limit");

endmodule : clamp_stage

// ==== core/hall_output_conditioning_dsp.sv ====
// Purpose: Output conditioning of a programmable linear field sensor
// Assumes: Commands arrive decoded and on this clock
// Notes: Settings image loaded from nonvolatile store after reset
//
// Summary of operation
// - Offset is added to scaled value; zero sample gives the offset.
// - Negative offset caps the highest output at offset plus supply.
// - Lower clamp sets minimum output, zero to half supply.
// - Upper clamp sets maximum output, zero to full supply.
// - Once locked, settings freeze and every command is ignored.
// - The lock has no clearing path, not even by reset.
// - The 14-bit raw field sample is readable before processing.
// - Output change is sensitivity times supply times sample over 2048.
// - Unlimited rewriting of settings while unlocked.
// - Write-and-store commits settings to the nonvolatile image.
// - Order: multiply, add offset, clamp, then drive converter.
// - Sensitivity spans -4 to 4 in steps of 1/2048.
// - Range is mode low three bits, filter the high three bits.

`timescale 1ns/1ps

module hall_output_conditioning_dsp
    import hall_dsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic raw_valid,
    input wire logic [hall_dsp_pkg::RAW_W-1:0] raw_sample,
    input wire hall_dsp_pkg::cmd_type cmd,
    input wire hall_dsp_pkg::nv_type nv_image_in,
    output hall_dsp_pkg::rsp_type rsp,
    output logic nvm_store,
    output hall_dsp_pkg::nv_type nvm_image,
    output logic locked,
    output logic [hall_dsp_pkg::FIELD3_W-1:0] range_sel,
    output logic [hall_dsp_pkg::FIELD3_W-1:0] filter_sel,
    output logic [hall_dsp_pkg::CLAMP_W-1:0] dac_code
);
    import hall_dsp_pkg::*;

    cond_state_type st_ff;
    cond_state_type nxt_st;
    logic cmd_live;
    logic store_taken;

    // ==========================================================
    // Command decode and datapath
    assign cmd_live = cmd.valid && !st_ff.lock && (st_ff.phase == PH_RUN);
    assign store_taken = cmd_live
        && (cmd.op == OP_STORE || cmd.op == OP_LOCK);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rsp = '0;
        nxt_st.store = 1'b0;
        if (st_ff.phase == PH_LOAD)
        begin
            nxt_st.phase = PH_RUN;
            nxt_st.lock = nv_image_in.lock;
            nxt_st.set = nv_image_in.set;
        end
        else if (cmd_live)
        begin
            unique case (cmd.op)
                OP_READ:
                begin
                    nxt_st.rsp.valid = 1'b1;
                    unique case (cmd.sel)
                        SEL_MODE:
                            nxt_st.rsp.data = DATA_W'(st_ff.set.mode);
                        SEL_SENS:
                            nxt_st.rsp.data = DATA_W'(st_ff.set.sens);
                        SEL_OFFSET:
                            nxt_st.rsp.data = DATA_W'(st_ff.set.offset);
                        SEL_CLAMP_LO:
                            nxt_st.rsp.data = DATA_W'(st_ff.set.clamp_lo);
                        SEL_CLAMP_HI:
                            nxt_st.rsp.data = DATA_W'(st_ff.set.clamp_hi);
                        SEL_RAW:
                            nxt_st.rsp.data = DATA_W'(st_ff.raw);
                        SEL_LOCK:
                            nxt_st.rsp.data = DATA_W'(st_ff.lock);
                        default:
                            nxt_st.rsp.data = '0;
                    endcase
                end
                OP_WRITE, OP_STORE:
                begin
                    unique case (cmd.sel)
                        SEL_MODE:
                            nxt_st.set.mode = cmd.data[MODE_W-1:0];
                        SEL_SENS:
                            nxt_st.set.sens = cmd.data[SENS_W-1:0];
                        SEL_OFFSET:
                            nxt_st.set.offset = cmd.data[OFS_W-1:0];
                        SEL_CLAMP_LO:
                        begin
                            if (cmd.data[CLAMP_W-1:0] > HALF_SCALE)
                            begin
                                nxt_st.set.clamp_lo = HALF_SCALE;
                            end
                            else
                            begin
                                nxt_st.set.clamp_lo = cmd.data[CLAMP_W-1:0];
                            end
                        end
                        SEL_CLAMP_HI:
                        begin
                            if (cmd.data[CLAMP_W-1:0] > FULL_SCALE)
                            begin
                                nxt_st.set.clamp_hi = FULL_SCALE;
                            end
                            else
                            begin
                                nxt_st.set.clamp_hi = cmd.data[CLAMP_W-1:0];
                            end
                        end
                        default:
                            nxt_st.set = st_ff.set;
                    endcase
                    nxt_st.store = (cmd.op == OP_STORE);
                end
                OP_LOCK:
                begin
                    nxt_st.lock = 1'b1;
                    nxt_st.store = 1'b1;
                end
            endcase
        end
        if (raw_valid)
        begin
            nxt_st.raw = raw_sample;
        end
        nxt_st.prod = PROD_W'($signed(st_ff.set.sens)
            * $signed(st_ff.raw));
        nxt_st.sum = SUM_W'($signed(st_ff.prod[PROD_W-1:SCALE_SHIFT]))
            + SUM_W'($signed({st_ff.set.offset, 1'b0}));
        if (st_ff.set.offset[OFS_W-1])
        begin
            nxt_st.ceil = SUM_W'($signed({st_ff.set.offset, 1'b0}))
                + SUM_W'(FULL_SCALE);
        end
        else
        begin
            nxt_st.ceil = SUM_W'(FULL_SCALE);
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.phase <= PH_LOAD;
            st_ff.lock <= LOCK_RST;
            st_ff.set <= SETTINGS_RST;
            st_ff.raw <= '0;
            st_ff.prod <= '0;
            st_ff.sum <= '0;
            st_ff.ceil <= '0;
            st_ff.rsp <= '0;
            st_ff.store <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Clamp and converter drive
    clamp_stage u_clamp (
        .clock(clock),
        .rst_n(rst_n),
        .sum(st_ff.sum),
        .ceil(st_ff.ceil),
        .clamp_lo(st_ff.set.clamp_lo),
        .clamp_hi(st_ff.set.clamp_hi),
        .dac_code(dac_code)
    );

    // ==========================================================
    // Outputs
    assign rsp = st_ff.rsp;
    assign nvm_store = st_ff.store;
    assign nvm_image.lock = st_ff.lock;
    assign nvm_image.set = st_ff.set;
    assign locked = st_ff.lock;
    assign range_sel = st_ff.set.mode[RANGE_LSB+:FIELD3_W];
    assign filter_sel = st_ff.set.mode[FILTER_LSB+:FIELD3_W];

    // ==========================================================
    // Checks
    property p_lock_sticky;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.lock && st_ff.phase == PH_RUN) |=> st_ff.lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock cleared");

    property p_locked_silent;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.lock && st_ff.phase == PH_RUN && cmd.valid)
        |=> (!rsp.valid && !nvm_store && $stable(st_ff.set));
    endproperty
    a_locked_silent: assert property (p_locked_silent)
        else $error("locked device reacted to a command");

    property p_read_raw;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_READ && cmd.sel == SEL_RAW)
        |=> (rsp.valid && rsp.data == DATA_W'($past(st_ff.raw)));
    endproperty
    a_read_raw: assert property (p_read_raw)
        else $error("raw sample read wrong");

    property p_scale;
        @(posedge clock) disable iff (!rst_n)
        ##1 (st_ff.prod == PROD_W'($signed($past(st_ff.set.sens))
            * $signed($past(st_ff.raw))));
    endproperty
    a_scale: assert property (p_scale)
        else $error("product wrong");

    property p_zero_offset;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.raw == '0 && raw_valid == 1'b0) ##1 $stable(st_ff.set)
        |=> (st_ff.sum == SUM_W'($signed({$past(st_ff.set.offset), 1'b0})));
    endproperty
    a_zero_offset: assert property (p_zero_offset)
        else $error("zero sample did not give offset");

    property p_ceiling;
        @(posedge clock) disable iff (!rst_n)
        st_ff.set.offset[OFS_W-1]
        |=> (st_ff.ceil == SUM_W'($signed({$past(st_ff.set.offset), 1'b0}))
            + SUM_W'(FULL_SCALE));
    endproperty
    a_ceiling: assert property (p_ceiling)
        else $error("negative offset ceiling wrong");

    property p_rewrite;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_WRITE && cmd.sel == SEL_SENS)
        |=> (st_ff.set.sens == $past(cmd.data[SENS_W-1:0]) && !nvm_store);
    endproperty
    a_rewrite: assert property (p_rewrite)
        else $error("unlocked write not taken");

    property p_store;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_STORE)
        |=> (nvm_store && nvm_image.set == st_ff.set)
            ##1 (!nvm_store || $past(store_taken));
    endproperty
    a_store: assert property (p_store)
        else $error("store pulse missing");

    property p_mode_fields;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_WRITE && cmd.sel == SEL_MODE)
        |=> (range_sel == $past(cmd.data[2:0])
            && filter_sel == $past(cmd.data[5:3]));
    endproperty
    a_mode_fields: assert property (p_mode_fields)
        else $error("mode fields misplaced");

    property p_limits;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_WRITE)
        |=> (st_ff.set.clamp_lo <= HALF_SCALE
            && st_ff.set.clamp_hi <= FULL_SCALE);
    endproperty
    a_limits: assert property (p_limits)
        else $error("clamp limit out of range");

    property p_lock_cmd;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op == OP_LOCK)
        |=> (locked && nvm_store && nvm_image.lock);
    endproperty
    a_lock_cmd: assert property (p_lock_cmd)
        else $error("lock command not committed");

    property p_clamp_lo_sat;
        @(posedge clock) disable iff (!rst_n)
        (cmd_live && cmd.op != OP_READ && cmd.op != OP_LOCK
            && cmd.sel == SEL_CLAMP_LO
            && cmd.data[CLAMP_W-1:0] > HALF_SCALE)
        |=> (st_ff.set.clamp_lo == HALF_SCALE);
    endproperty
    a_clamp_lo_sat: assert property (p_clamp_lo_sat)
        else $error("lower clamp limit not saturated");

    property p_image_load;
        @(posedge clock) disable iff (!rst_n)
        (st_ff.phase == PH_LOAD)
        |=> (locked == $past(nv_image_in.lock)
            && nvm_image.set == $past(nv_image_in.set));
    endproperty
    a_image_load: assert property (p_image_load)
        else $error("settings image not loaded after reset");

endmodule : hall_output_conditioning_dsp

// ==== tb/prog_tool_model.sv ====
// Purpose: Programming tool model issuing decoded supply-modulation commands
// Assumes: Command launched on a falling edge, taken on the next rising edge
// Notes: Released command bus shows inverted data so stale values never match

`timescale 1ns/1ps

module prog_tool_model
    import hall_dsp_pkg::*;
(
    input wire logic clock,
    input wire hall_dsp_pkg::rsp_type rsp,
    output hall_dsp_pkg::cmd_type cmd
);
    import hall_dsp_pkg::*;

    // ==========================================================
    // Command issue
    initial cmd = '0;

    task automatic send(input op_type op, input logic [SEL_W-1:0] sel,
        input logic [DATA_W-1:0] data, output rsp_type got);
        @(negedge clock);
        cmd = '{valid: 1'b1, op: op, sel: sel, data: data};
        @(negedge clock);
        got = rsp;
        cmd = '{valid: 1'b0, op: OP_READ, sel: ~sel, data: ~data};
    endtask : send

    // Lock is issued directly; the lock command itself stores the current settings
    task automatic finish_calibration(output rsp_type got);
        send(OP_LOCK, SEL_LOCK, 16'h0001, got);
    endtask : finish_calibration
endmodule : prog_tool_model

// ==== tb/hall_output_conditioning_dsp_bench.sv ====
// Purpose: Self-checking bench of the output-conditioning path
// Assumes: Nonvolatile store modelled here, written on each store pulse
// Notes: Random settings with corner cases, fixed seed

`timescale 1ns/1ps

module hall_output_conditioning_dsp_bench;
    import hall_dsp_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic raw_valid = 1'b0;
    logic [RAW_W-1:0] raw_sample = '0;
    cmd_type cmd;
    nv_type nv_image_in;
    nv_type nv_mem = '{lock: 1'b0, set: '{mode: 6'h13, sens: 14'h0800,
        offset: 11'h000, clamp_lo: 12'h000, clamp_hi: 12'h800}};
    rsp_type rsp;
    rsp_type got;
    logic nvm_store;
    nv_type nvm_image;
    logic locked;
    logic [FIELD3_W-1:0] range_sel;
    logic [FIELD3_W-1:0] filter_sel;
    logic [CLAMP_W-1:0] dac_code;
    settings_type s;
    logic [RAW_W-1:0] r;
    integer seed = 32'h4FE663E1;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    // ==========================================================
    // Clock, store and watchdog
    always #2.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (nvm_store === 1'b1)
            nv_mem <= nvm_image;
        if (cycles > 20000)
        begin
            n_errors = n_errors + 1;
            test_done();
        end
    end

    assign nv_image_in = nv_mem;

    hall_output_conditioning_dsp dut (
        .clock(clock),
        .rst_n(rst_n),
        .raw_valid(raw_valid),
        .raw_sample(raw_sample),
        .cmd(cmd),
        .nv_image_in(nv_image_in),
        .rsp(rsp),
        .nvm_store(nvm_store),
        .nvm_image(nvm_image),
        .locked(locked),
        .range_sel(range_sel),
        .filter_sel(filter_sel),
        .dac_code(dac_code)
    );

    prog_tool_model tool (
        .clock(clock),
        .rsp(rsp),
        .cmd(cmd)
    );

    // ==========================================================
    // Helpers
    task automatic test_done();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [63:0] seen,
        input logic [63:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (12) @(negedge clock);
        chk("locked_in_reset", 64'(locked), 64'h1);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : do_reset

    task automatic wr(input logic [SEL_W-1:0] sel, input logic [15:0] d);
        tool.send(OP_WRITE, sel, d, got);
    endtask : wr

    task automatic rd(input string name, input logic [SEL_W-1:0] sel,
        input logic [16:0] exp);
        tool.send(OP_READ, sel, 16'h0000, got);
        chk(name, 64'({got.valid, got.data}), 64'(exp));
    endtask : rd

    function automatic logic [CLAMP_W-1:0] exp_dac(input settings_type st,
        input logic [RAW_W-1:0] rw);
        int p;
        int ofs;
        int sm;
        int top;
        p = int'($signed(st.sens)) * int'($signed(rw));
        ofs = int'($signed(st.offset));
        sm = (p >>> SCALE_SHIFT) + 2 * ofs;
        top = (ofs < 0) ? 2 * ofs + 2048 : 2048;
        if (int'(st.clamp_hi) < top)
            top = int'(st.clamp_hi);
        if (sm < int'(st.clamp_lo))
            return st.clamp_lo;
        if (sm > top)
            return CLAMP_W'(top);
        return CLAMP_W'(sm);
    endfunction : exp_dac

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        chk("nv_load", 64'(nvm_image), 64'(nv_mem));
        chk("unlocked", 64'(locked), 64'h0);
        // Repeated rewriting of every setting
        for (int i = 0; i < 24; i++)
        begin
            s.mode = 6'($random(seed));
            s.sens = 14'($random(seed));
            s.offset = 11'(($unsigned($random(seed)) % 1536) - 512);
            s.clamp_lo = 12'($unsigned($random(seed)) % 1025);
            s.clamp_hi = 12'(s.clamp_lo
                + $unsigned($random(seed)) % (2049 - int'(s.clamp_lo)));
            r = 14'($random(seed));
            if (i == 0)
            begin
                r = '0;
                s.offset = 11'h155;
                s.clamp_lo = 12'h000;
            end
            if (i == 1)
            begin
                s.sens = 14'h1FFF;
                s.offset = 11'h600;
                r = 14'h1FFF;
                s.clamp_hi = 12'h800;
            end
            if (i == 2)
            begin
                s.sens = 14'h2000;
                r = 14'h1000;
            end
            if (i == 3)
            begin
                s.sens = 14'h0800;
                r = 14'h0100;
            end
            wr(SEL_MODE, 16'(s.mode));
            wr(SEL_SENS, 16'(s.sens));
            wr(SEL_OFFSET, 16'(s.offset));
            wr(SEL_CLAMP_LO, 16'(s.clamp_lo));
            wr(SEL_CLAMP_HI, 16'(s.clamp_hi));
            @(negedge clock);
            raw_sample = r;
            raw_valid = 1'b1;
            @(negedge clock);
            raw_valid = 1'b0;
            raw_sample = ~r;
            repeat (5) @(negedge clock);
            chk("dac_code", 64'(dac_code), 64'(exp_dac(s, r)));
            chk("range_sel", 64'(range_sel), 64'(s.mode[2:0]));
            chk("filter_sel", 64'(filter_sel), 64'(s.mode[5:3]));
            rd("raw_read", SEL_RAW, {3'b100, r});
            rd("sens_read", SEL_SENS, {3'b100, s.sens});
            rd("offset_read", SEL_OFFSET, {6'b100000, s.offset});
        end
        // Out-of-range clamp writes saturate at their documented span
        wr(SEL_CLAMP_LO, 16'h0FFF);
        rd("clamp_lo_sat", SEL_CLAMP_LO, {5'b10000, HALF_SCALE});
        wr(SEL_CLAMP_HI, 16'h0FFF);
        rd("clamp_hi_sat", SEL_CLAMP_HI, {5'b10000, FULL_SCALE});
        rd("unmapped_read", 3'h7, 17'h10000);
        s.clamp_lo = HALF_SCALE;
        s.clamp_hi = FULL_SCALE;
        s.mode = 6'h2D;
        // Store then power cycle: settings come back from the image
        tool.send(OP_STORE, SEL_MODE, 16'h002D, got);
        chk("store_pulse", 64'(nvm_store), 64'h1);
        chk("store_img", 64'(nvm_image.set), 64'(s));
        do_reset();
        chk("set_kept", 64'(nvm_image.set), 64'(s));
        chk("mode_kept", 64'({filter_sel, range_sel}), 64'h2D);
        rd("mode_read", SEL_MODE, {11'h400, s.mode});
        rd("lock_read", SEL_LOCK, 17'h10000);
        // Lock, then a write and a read are ignored, and a read also after reset
        tool.finish_calibration(got);
        chk("lock_flag", 64'(locked), 64'h1);
        chk("lock_store", 64'(nvm_store), 64'h1);
        chk("lock_img", 64'(nvm_image.lock), 64'h1);
        wr(SEL_SENS, 16'h0123);
        rd("read_locked", SEL_RAW, 17'h00000);
        chk("no_rsp", 64'(got.valid), 64'h0);
        chk("frozen", 64'(nvm_image.set), 64'(s));
        do_reset();
        chk("lock_kept", 64'(locked), 64'h1);
        tool.send(OP_READ, SEL_SENS, 16'h0000, got);
        chk("no_rsp_reset", 64'(got.valid), 64'h0);
        test_done();
    end
endmodule : hall_output_conditioning_dsp_bench
